/* File: pkg/mrost_pkg.sv */
// Notes on behaviour
// RL1: Reset fires only after a long-press input has stayed low without a break for the whole setup period, and shorter presses do nothing.
// RL2: A valid manual condition drives the active-low reset output low as one pulse of the fixed timeout length, then releases it.
// RL3: In the dual long-press mode the setup timer runs only while both inputs are low together.
// RL4: Exactly one pulse is produced per valid press, and an input must go high and be held low again for a full setup period before the next one.
// RL5: Rising edges on long-press input A are debounced inside the block, so its release bounce causes no harm; the second input is used raw in dual mode.
// RL6: In immediate mode a rising edge on the active-high input asserts reset at once for the timeout period.
// RL7: A new rising edge on the immediate input before the timeout ends restarts the timeout while reset stays asserted.
// RL8: Reset is released once the timeout passes with no further rising edge on the immediate input.
// RL9: Falling transitions on the immediate input are debounced for their interval, so card removal never causes a reset.
// RL10: The block is set up as single long-press, dual long-press, or long-press plus immediate, all sharing the same timings.
// RL11: Reset is held low while a supply is below threshold and for one timeout period after all supplies recover.
// RL12: Intervals are counted on the free-running clock with terminal counts as parameters, and a long-press input going high clears the setup count.
// RL13: The reset output is the OR of supply and manual requests, and no new request from either source shortens an asserted pulse.
package mrost_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETUP_MS = 6720;
  localparam int unsigned PULSE_MS = 140;
  localparam int unsigned IMM_DEB_MS = 210;
  localparam int unsigned RLS_DEB_MS = 20;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned SETUP_TICKS = SETUP_MS;
  localparam int unsigned PULSE_TICKS = PULSE_MS;
  localparam int unsigned IMM_DEB_TICKS = IMM_DEB_MS;
  localparam int unsigned RLS_DEB_TICKS = RLS_DEB_MS;
  localparam int unsigned TICK_W = 16;
  typedef enum logic [1:0] {
    MROST_MODE_SINGLE,
    MROST_MODE_DUAL,
    MROST_MODE_IMMEDIATE
  } mrost_mode_type;
endpackage : mrost_pkg

/* File: core/mrost_tick.sv */
`timescale 1ns/100ps
module mrost_tick
  import mrost_pkg::*;
#(
  parameter int unsigned DIV = MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Millisecond enable.
  output logic tick_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mrost_tick_state_type;
  mrost_tick_state_type s_reg;
  mrost_tick_state_type s_next;
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= DIV - 1) begin
      s_next.cnt = 32'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign tick_out = s_reg.tick;
endmodule : mrost_tick

/* File: core/mrost_core.sv */
`timescale 1ns/100ps
module mrost_core
  import mrost_pkg::*;
#(
  parameter int unsigned TICK_DIV = MS_CYCLES,
  parameter int unsigned SETUP_TC = SETUP_TICKS,
  parameter int unsigned PULSE_TC = PULSE_TICKS,
  parameter int unsigned IMM_DEB_TC = IMM_DEB_TICKS,
  parameter int unsigned RLS_DEB_TC = RLS_DEB_TICKS
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Configuration.
  input wire mrost_mode_type mode_in,
  // Manual inputs and supply status.
  input wire logic long_press_input_a_n_in,
  input wire logic second_manual_input_in,
  input wire logic supply_low_in,
  // Reset toward the processor.
  output logic reset_n_out
);
  typedef struct packed {
    logic [TICK_W-1:0] setup_cnt;
    logic armed;
    logic [TICK_W-1:0] rls_cnt;
    logic a_low;
    logic b_low;
    logic [TICK_W-1:0] pulse_cnt;
    logic [TICK_W-1:0] por_cnt;
    logic por_busy;
    logic imm_lvl;
    logic [TICK_W-1:0] imm_deb;
    logic rst_n;
  } mrost_core_state_type;
  mrost_core_state_type s_reg;
  mrost_core_state_type s_next;
  logic tick;
  logic cond;
  logic imm_rise;
  mrost_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tick_out(tick)
  );
  always_comb begin
    s_next = s_reg;
    // Falling edges take effect at once; a release must hold for the debounce interval.
    if (!long_press_input_a_n_in) begin
      s_next.a_low = 1'b1;
      s_next.rls_cnt = '0;
    end else if (s_reg.a_low && tick) begin
      s_next.rls_cnt = s_reg.rls_cnt + 1'b1;
      if (s_reg.rls_cnt >= TICK_W'(RLS_DEB_TC - 1)) begin
        s_next.a_low = 1'b0; // see RL5
        s_next.rls_cnt = '0;
      end
    end
    s_next.b_low = !second_manual_input_in;
    // The immediate input: rises pass at once, falls must persist for the debounce interval.
    imm_rise = 1'b0;
    if (second_manual_input_in) begin
      s_next.imm_deb = '0;
      if (!s_reg.imm_lvl) begin
        s_next.imm_lvl = 1'b1;
        imm_rise = 1'b1; // see RL6
      end
    end else if (s_reg.imm_lvl && tick) begin
      s_next.imm_deb = s_reg.imm_deb + 1'b1;
      if (s_reg.imm_deb >= TICK_W'(IMM_DEB_TC - 1)) begin
        s_next.imm_lvl = 1'b0; // see RL9
        s_next.imm_deb = '0;
      end
    end
    unique case (mode_in)
      MROST_MODE_SINGLE: cond = s_reg.a_low; // see RL10
      MROST_MODE_DUAL: cond = s_reg.a_low && s_reg.b_low; // see RL3
      MROST_MODE_IMMEDIATE: cond = s_reg.a_low;
      default: cond = 1'b0;
    endcase
    if (mode_in != MROST_MODE_IMMEDIATE) begin
      imm_rise = 1'b0;
    end
    // Setup count clears on any break in the condition and fires once per press.
    if (!cond) begin
      s_next.setup_cnt = '0; // see RL12
      s_next.armed = 1'b1; // see RL4
    end else if (long_press_input_a_n_in) begin
      // A raw high on input A, even inside the release debounce, restarts the count so only an unbroken press fires.
      s_next.setup_cnt = '0; // see RL1
    end else if (s_reg.armed && tick) begin
      s_next.setup_cnt = s_reg.setup_cnt + 1'b1;
      if (s_reg.setup_cnt >= TICK_W'(SETUP_TC - 1)) begin
        s_next.armed = 1'b0; // see RL1
        s_next.setup_cnt = '0;
        s_next.pulse_cnt = TICK_W'(PULSE_TC); // see RL2
      end
    end
    if (imm_rise) begin
      s_next.pulse_cnt = TICK_W'(PULSE_TC); // see RL7
    end else if (s_reg.pulse_cnt != '0 && tick && s_next.pulse_cnt == s_reg.pulse_cnt) begin
      s_next.pulse_cnt = s_reg.pulse_cnt - 1'b1; // see RL8
    end
    // Supply path holds reset while low and for one timeout after recovery.
    if (supply_low_in) begin
      s_next.por_busy = 1'b1;
      s_next.por_cnt = TICK_W'(PULSE_TC); // see RL11
    end else if (s_reg.por_busy && tick) begin
      if (s_reg.por_cnt <= TICK_W'(1)) begin
        s_next.por_busy = 1'b0;
        s_next.por_cnt = '0;
      end else begin
        s_next.por_cnt = s_reg.por_cnt - 1'b1;
      end
    end
    s_next.rst_n = !(s_next.por_busy || s_next.pulse_cnt != '0); // see RL13
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
      s_reg.por_busy <= 1'b1;
      s_reg.por_cnt <= TICK_W'(PULSE_TC);
      s_reg.armed <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign reset_n_out = s_reg.rst_n;
endmodule : mrost_core

/* File: testbench/mrost_button.sv */
`timescale 1ns/100ps
module mrost_button (
  input wire logic clk_in,
  input wire logic press_in,
  output logic btn_n_out = 1'b1
);
  logic [2:0] bnc_reg = 3'h0;
  always @(posedge clk_in) begin
    bnc_reg <= press_in ? 3'h7 : bnc_reg - 3'(bnc_reg != 3'h0);
    btn_n_out <= !press_in && (bnc_reg == 3'h0 || bnc_reg[0]);
  end
endmodule : mrost_button

/* File: testbench/mrost_chk.sv */
`timescale 1ns/100ps
module mrost_chk
  import mrost_pkg::*;
#(parameter int unsigned TICK_DIV = 10, parameter int unsigned PULSE_TC = 5, parameter int unsigned IMM_DEB_TC = 6) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire mrost_mode_type mode_in,
  input wire logic long_press_input_a_n_in,
  input wire logic second_manual_input_in,
  input wire logic supply_low_in,
  input wire logic reset_n_out
);
  logic [15:0] lo_reg;
  logic [15:0] bl_reg;
  logic [15:0] hi_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lo_reg <= 16'h0;
      bl_reg <= 16'h0;
      hi_reg <= 16'h0;
    end else begin
      lo_reg <= reset_n_out ? 16'h0 : lo_reg + 16'h1;
      bl_reg <= second_manual_input_in ? 16'h0 : bl_reg + 16'h1;
      hi_reg <= (!reset_n_out || supply_low_in) ? 16'h0 : hi_reg + 16'(hi_reg != 16'hFFFF);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence fire_s;
    $fell(reset_n_out) && !$past(supply_low_in);
  endsequence
  power_on_a: assert property ($rose(rstn_in) |-> !reset_n_out [*8]) else $error("early release");
  supply_a: assert property (supply_low_in |=> !reset_n_out) else $error("supply ignored");
  supply_tail_a: assert property ($fell(supply_low_in) |-> !reset_n_out [*8]) else $error("short tail");
  single_a: assert property (fire_s ##0 mode_in == MROST_MODE_SINGLE
    |-> !$past(long_press_input_a_n_in, 3)) else $error("early single");
  dual_a: assert property (fire_s ##0 mode_in == MROST_MODE_DUAL
    |-> !$past(long_press_input_a_n_in, 3) && !$past(second_manual_input_in, 3)) else $error("early dual");
  width_a: assert property ($rose(reset_n_out) |-> lo_reg >= (PULSE_TC - 1) * TICK_DIV - 2)
    else $error("short pulse");
  imm_a: assert property (mode_in == MROST_MODE_IMMEDIATE && $rose(second_manual_input_in)
    && bl_reg > (IMM_DEB_TC + 1) * TICK_DIV |=> !reset_n_out [*8]) else $error("missed rise");
  one_a: assert property (mode_in == MROST_MODE_SINGLE && !supply_low_in && hi_reg != 16'h0 && hi_reg < 16'h9
    |-> reset_n_out) else $error("second pulse");
endmodule : mrost_chk
bind mrost_core mrost_chk #(.TICK_DIV(TICK_DIV), .PULSE_TC(PULSE_TC), .IMM_DEB_TC(IMM_DEB_TC)) chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .mode_in(mode_in), .long_press_input_a_n_in(long_press_input_a_n_in),
  .second_manual_input_in(second_manual_input_in), .supply_low_in(supply_low_in), .reset_n_out(reset_n_out));

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import mrost_pkg::*;
  localparam int D = 10, S = 20, L = 40, H = 53;
  logic clk_in = 0, rstn_in = 0, press = 0, b_in = 0, sup = 0, prev = 0, a_n, rst_n;
  mrost_mode_type mode = MROST_MODE_SINGLE;
  int errors = 0, num_checks = 0, falls = 0, lows = 0, seed = 32'h83fc6ab0, i, n;
  always #5 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    falls += (prev === 1'b1 && rst_n === 1'b0);
    lows += (rst_n !== 1'b1);
    prev = rst_n;
  end
  mrost_button btn (.clk_in(clk_in), .press_in(press), .btn_n_out(a_n));
  mrost_core #(.TICK_DIV(D), .SETUP_TC(S), .PULSE_TC(5), .IMM_DEB_TC(2), .RLS_DEB_TC(3)) dut (.clk_in(clk_in),
    .rstn_in(rstn_in), .mode_in(mode), .long_press_input_a_n_in(a_n), .second_manual_input_in(b_in),
    .supply_low_in(sup), .reset_n_out(rst_n));
  function automatic int fire(input int c);
    return c > S * D;
  endfunction : fire
  task automatic drive(input logic a, input logic b, input logic s, input int c);
    press <= a;
    b_in <= b;
    sup <= s;
    repeat (c) @(posedge clk_in);
  endtask : drive
  task automatic expect_run(input int f, input int lo, input int hi);
    drive(0, mode == MROST_MODE_DUAL, 0, 120);
    num_checks++;
    if (falls !== f || lows < lo || lows > hi) begin
      errors++;
      $display("[ERR] %0t falls %0d low cycles %0d", $time, falls, lows);
    end
    $display("test done at %0t", $time);
    falls = 0;
    lows = 0;
  endtask : expect_run
  task automatic restart(input mrost_mode_type m);
    rstn_in <= 0;
    mode <= m;
    drive(0, m == MROST_MODE_DUAL, 0, 6);
    falls = 0;
    lows = 0;
    rstn_in <= 1;
    expect_run(0, L, H);
  endtask : restart
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    restart(MROST_MODE_SINGLE);
    drive(1, 1, 0, (S - 1) * D);
    expect_run(0, 0, 0);
    for (i = 0; i < 8; i++) begin
      n = i < 2 ? (S + 1 + i * 2 * S) * D : S * D / 2 + $unsigned($random(seed)) % (2 * S * D);
      if (n > (S - 1) * D && n <= (S + 1) * D) n += 2 * D;
      drive(1, 1'($random(seed)), 0, n);
      expect_run(fire(n), fire(n) * L, fire(n) * H);
    end
    restart(MROST_MODE_DUAL);
    drive(1, 1, 0, 3 * S * D);
    expect_run(0, 0, 0);
    drive(1, 0, 0, S * D / 2);
    drive(1, 1, 0, D);
    drive(1, 0, 0, (S - 1) * D);
    expect_run(0, 0, 0);
    drive(1, 0, 0, (S + 2) * D);
    expect_run(1, L, H);
    restart(MROST_MODE_IMMEDIATE);
    drive(0, 1, 0, 5);
    drive(0, 0, 0, 35);
    drive(0, 1, 0, 200);
    expect_run(1, 40 + L, 40 + H);
    drive(0, 1, 0, 60);
    drive(0, 0, 0, 5);
    drive(0, 1, 0, 60);
    expect_run(1, L, H);
    drive(0, 1, 0, 30);
    drive(0, 1, 1, 10);
    expect_run(1, 40 + L, 40 + H);
    complete_run;
  end
endmodule : testbench
